// >>> hw/sync_burst_sram_pkg.sv
package sync_burst_sram_pkg;

	// Organisation: 4M words of four 9-bit byte lanes
	localparam int DATA_W = 36;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int ADDR_W = 22;
	localparam int DEPTH = 4194304;
	localparam int LSB_W = 2;

	// Burst beat counter values
	localparam logic [LSB_W-1:0] BEAT_FIRST = 2'h0;
	localparam logic [LSB_W-1:0] BEAT_STEP = 2'h1;
	localparam logic [LSB_W-1:0] BEAT_LAST = 2'h3;

	// Byte lane write masks
	localparam logic [LANES-1:0] LANES_ALL = 4'hf;
	localparam logic [LANES-1:0] LANES_NONE = 4'h0;

	// Cycle operation decoded from the synchronous controls
	typedef enum logic [2:0] {
		OP_IDLE = 3'b000,
		OP_DESELECT = 3'b001,
		OP_READ_BEGIN = 3'b010,
		OP_WRITE_BEGIN = 3'b011,
		OP_CONTINUE = 3'b100
	} op_type;

	// Burst address state
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LSB_W-1:0] start;
		logic [LSB_W-1:0] beat;
	} burst_type;

	// One read data stage with its driver request
	typedef struct packed {
		logic drive;
		logic [DATA_W-1:0] data;
	} stage_type;

	// Complete control state of the port
	typedef struct packed {
		burst_type burst;
		stage_type flow;
		stage_type pipe;
	} state_type;

	localparam state_type STATE_RESET = '0;

endpackage

// >>> hw/sync_burst_sram_port.sv
// Functional notes
// - Inputs sampled on rising clock edge
// - Output enable and sleep act asynchronously
// - Either address strobe loads external address
// - 2-bit counter advances only with burst_step
// - Linear order when select low, else interleaved
// - Floating mode pins give interleaved pipelined
// - New external address accepted every cycle
// - Select low: reads bypass output register
// - Select high: reads through output register
// - Deselect pipelined as deep as reads
// - Byte gate writes only enabled lanes
// - Global write writes every lane
// - Sleep or stopped clock keeps contents
// - Writes self-timed, no write strobe pulse
// - Lane enables a-d map to lanes, low
// - Both chip selects are active low
// - Data driven only while output enable low
// - Low address bits also preset counter
// - Burst step and strobes active low
// - Word 36 bits, 4M words deep
// - Four-beat wrap, linear add or XOR
// - Data pins undriven in the cycle after every write
// - Enable high kills drivers, low only re-enables
module sync_burst_sram_port
	import sync_burst_sram_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [ADDR_W-1:LSB_W] addr_upper,
	input wire logic addr_lsb_zero,
	input wire logic addr_lsb_one,
	input wire logic chip_select_one_n,
	input wire logic chip_select_three_n,
	input wire logic addr_strobe_cpu_n,
	input wire logic addr_strobe_ctrl_n,
	input wire logic burst_step_n,
	input wire logic byte_write_gate_n,
	input wire logic all_bytes_write_n,
	input wire logic byte_en_a_n,
	input wire logic byte_en_b_n,
	input wire logic byte_en_c_n,
	input wire logic byte_en_d_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic bypass_select,
	input wire logic burst_order_linear_n,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe
);

	// Low address bits of a beat in the selected order
	function automatic logic [LSB_W-1:0] burst_low(input logic [LSB_W-1:0] start,
		input logic [LSB_W-1:0] beat, input logic linear_n);
		if (!linear_n) begin
			burst_low = start + beat;
		end else begin
			burst_low = start ^ beat;
		end
	endfunction

	state_type st;
	state_type next_st;
	op_type op;
	logic [DATA_W-1:0] mem [DEPTH];
	logic [ADDR_W-1:0] eff_addr;
	logic [LANES-1:0] lane_mask;
	logic [LANES-1:0] mem_we;
	logic [LSB_W-1:0] next_beat;
	logic cs_on;
	logic is_write;
	logic load;
	logic adv_go;
	logic do_read;
	logic do_write;
	logic stage_drive;

	// Decode the cycle, walk the burst and fill the read stages
	always_comb begin
		next_st = st;
		cs_on = !chip_select_one_n && !chip_select_three_n;
		is_write = !all_bytes_write_n || !byte_write_gate_n;
		if (!all_bytes_write_n) begin
			lane_mask = LANES_ALL;
		end else if (!byte_write_gate_n) begin
			lane_mask = ~{byte_en_d_n, byte_en_c_n, byte_en_b_n, byte_en_a_n};
		end else begin
			lane_mask = LANES_NONE;
		end
		// Sleep blocks all synchronous operations
		if (sleep_request) begin
			op = OP_IDLE;
		end else if ((!chip_select_one_n && chip_select_three_n &&
			(!addr_strobe_cpu_n || !addr_strobe_ctrl_n)) ||
			(chip_select_one_n && !addr_strobe_ctrl_n)) begin
			op = OP_DESELECT;
		end else if (cs_on && !addr_strobe_cpu_n) begin
			op = OP_READ_BEGIN;
		end else if (cs_on && !addr_strobe_ctrl_n) begin
			op = is_write ? OP_WRITE_BEGIN : OP_READ_BEGIN;
		end else begin
			op = OP_CONTINUE;
		end
		load = (op == OP_READ_BEGIN) || (op == OP_WRITE_BEGIN);
		adv_go = (op == OP_CONTINUE) && !burst_step_n;
		next_beat = adv_go ? st.burst.beat + BEAT_STEP : st.burst.beat;
		// External address used in its own cycle, no lost throughput
		if (load) begin
			eff_addr = {addr_upper, addr_lsb_one, addr_lsb_zero};
			next_st.burst.addr = eff_addr;
			next_st.burst.start = {addr_lsb_one, addr_lsb_zero};
			next_st.burst.beat = BEAT_FIRST;
		end else begin
			eff_addr = {st.burst.addr[ADDR_W-1:LSB_W],
				burst_low(st.burst.start, next_beat, burst_order_linear_n)};
			if (op == OP_CONTINUE) begin
				next_st.burst.beat = next_beat;
			end
		end
		do_write = (op == OP_WRITE_BEGIN) || ((op == OP_CONTINUE) && is_write);
		do_read = (op == OP_READ_BEGIN) || ((op == OP_CONTINUE) && !is_write);
		mem_we = do_write ? lane_mask : LANES_NONE;
		// First stage: array output, drivers follow reads only
		next_st.flow.drive = do_read;
		if (do_read) begin
			next_st.flow.data = mem[eff_addr];
		end
		// Second stage: output register, deselect delayed one more edge
		next_st.pipe.drive = st.flow.drive && !do_write && !sleep_request;
		next_st.pipe.data = st.flow.data;
	end

	// Control state register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Self-timed lane writes into the array, kept through sleep
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < LANES; i++) begin
			if (mem_we[i]) begin
				mem[eff_addr][i*LANE_W +: LANE_W] <= data_in[i*LANE_W +: LANE_W];
			end
		end
	end

	// Mode select and asynchronous driver gating
	always_comb begin
		// Pad pulls leave the select high, so pipelined is the idle mode
		data_out = bypass_select ? st.pipe.data : st.flow.data;
		stage_drive = bypass_select ? st.pipe.drive : st.flow.drive;
		data_oe = stage_drive && !output_enable_n && !sleep_request;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	property p_oe_low_only;
		data_oe |-> !output_enable_n && !sleep_request;
	endproperty
	a_oe_low_only: assert property (p_oe_low_only) else $error("data driven with enable high");

	property p_write_quiet;
		do_write |=> !data_oe;
	endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("data driven after write");

	property p_dual_off;
		(op == OP_DESELECT && bypass_select) ##1 bypass_select |=> !data_oe;
	endproperty
	a_dual_off: assert property (p_dual_off) else $error("deselect not off after two edges");

	property p_pipe_read;
		(do_read && bypass_select) ##1 (!do_write && !sleep_request) ##1
			(bypass_select && !output_enable_n && !sleep_request) |-> data_oe;
	endproperty
	a_pipe_read: assert property (p_pipe_read) else $error("pipelined read not driven");

	property p_flow_read;
		do_read ##1 (!bypass_select && !output_enable_n && !sleep_request) |->
			data_oe && data_out == st.flow.data;
	endproperty
	a_flow_read: assert property (p_flow_read) else $error("flow read not driven");

	property p_step;
		(op == OP_CONTINUE) |=> st.burst.beat == $past(st.burst.beat) + ($past(burst_step_n) ?
			BEAT_FIRST : BEAT_STEP);
	endproperty
	a_step: assert property (p_step) else $error("burst counter step wrong");

	property p_wrap;
		(adv_go && st.burst.beat == BEAT_LAST) |-> eff_addr[LSB_W-1:0] == st.burst.start;
	endproperty
	a_wrap: assert property (p_wrap) else $error("burst did not wrap to start");

	property p_load;
		load |-> eff_addr == {addr_upper, addr_lsb_one, addr_lsb_zero} ##1
			st.burst.beat == BEAT_FIRST;
	endproperty
	a_load: assert property (p_load) else $error("strobe did not load address");

	property p_global;
		(do_write && !all_bytes_write_n) |-> mem_we == LANES_ALL;
	endproperty
	a_global: assert property (p_global) else $error("global write missed a lane");

	property p_sleep;
		sleep_request |-> mem_we == LANES_NONE && !data_oe;
	endproperty
	a_sleep: assert property (p_sleep) else $error("activity during sleep");

	// A suspended beat keeps the counter where it was
	property p_suspend;
		(op == OP_CONTINUE && burst_step_n) |=> st.burst.beat == $past(st.burst.beat);
	endproperty
	a_suspend: assert property (p_suspend) else $error("counter moved on suspend");

	// A strobe presets the counter from the two low address pins
	property p_load_beat;
		load |=> st.burst.beat == BEAT_FIRST &&
			st.burst.start == {$past(addr_lsb_one), $past(addr_lsb_zero)};
	endproperty
	a_load_beat: assert property (p_load_beat) else $error("counter preset wrong");

	// A deselect clears the first read stage at once
	property p_deselect_flow;
		(op == OP_DESELECT) |=> !st.flow.drive;
	endproperty
	a_deselect_flow: assert property (p_deselect_flow) else $error("deselect left drive");

	// Byte gated writes touch only the enabled lanes
	property p_byte_lanes;
		(do_write && all_bytes_write_n) |->
			mem_we == ~{byte_en_d_n, byte_en_c_n, byte_en_b_n, byte_en_a_n};
	endproperty
	a_byte_lanes: assert property (p_byte_lanes) else $error("byte lanes wrong");

	// Sleep freezes the burst state
	property p_sleep_hold;
		sleep_request |=> st.burst == $past(st.burst);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("burst state moved in sleep");

	// The first beat of either order is the start address
	property p_first_beat;
		(op == OP_CONTINUE && !adv_go && st.burst.beat == BEAT_FIRST) |->
			eff_addr[LSB_W-1:0] == st.burst.start;
	endproperty
	a_first_beat: assert property (p_first_beat) else $error("first beat not start");

	// A write begin stores in its own cycle, no strobe pulse
	property p_write_mask;
		(op == OP_WRITE_BEGIN) |-> mem_we == lane_mask;
	endproperty
	a_write_mask: assert property (p_write_mask) else $error("write not stored");

	// First chip select high with controller strobe is a deselect
	property p_chip_off;
		(chip_select_one_n && !addr_strobe_ctrl_n && !sleep_request) |-> op == OP_DESELECT;
	endproperty
	a_chip_off: assert property (p_chip_off) else $error("chip select ignored");

	// Pipelined mode shows the output register
	property p_mode_mux;
		bypass_select |-> data_out == st.pipe.data;
	endproperty
	a_mode_mux: assert property (p_mode_mux) else $error("output register bypassed");

	// Output enable high always silences the drivers
	property p_enable_off;
		output_enable_n |-> !data_oe;
	endproperty
	a_enable_off: assert property (p_enable_off) else $error("driven with enable high");

	property p_cov_deselect;
		op == OP_DESELECT && st.flow.drive;
	endproperty
	c_cov_deselect: cover property (p_cov_deselect);

	property p_cov_pipe;
		(do_read && bypass_select) ##2 data_oe;
	endproperty
	c_cov_pipe: cover property (p_cov_pipe);

	property p_cov_flow;
		(do_read && !bypass_select) ##1 data_oe;
	endproperty
	c_cov_flow: cover property (p_cov_flow);

	property p_cov_wrap;
		adv_go && st.burst.beat == BEAT_LAST;
	endproperty
	c_cov_wrap: cover property (p_cov_wrap);

	property p_cov_bytes;
		do_write && all_bytes_write_n && mem_we != LANES_ALL && mem_we != LANES_NONE;
	endproperty
	c_cov_bytes: cover property (p_cov_bytes);

endmodule

// >>> dv/host_bus_model.sv
// Host side of the memory port: chip selects, strobes and write controls
module host_bus_model
	import sync_burst_sram_pkg::*;
(
	output logic [ADDR_W-1:0] addr,
	output logic [1:0] cs_n,
	output logic cpu_n,
	output logic ctrl_n,
	output logic step_n,
	output logic glob_n,
	output logic gate_n,
	output logic [3:0] lane_n,
	output logic [DATA_W-1:0] wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// One cycle of controls, set after a falling edge, held to the rising edge
	task automatic drive(input logic [4:0] c, input logic [ADDR_W-1:0] a,
		input logic [3:0] ln, input logic [DATA_W-1:0] d);
		cs_n = 2'h0;
		{cpu_n, ctrl_n, step_n, glob_n, gate_n} = c;
		addr = a;
		lane_n = ln;
		wdata = d;
	endtask

	// Deselect; released data flips so a stale value never passes
	task automatic idle();
		cs_n = 2'h1;
		{cpu_n, ctrl_n, step_n, glob_n, gate_n} = 5'h17;
		addr = ~addr;
		wdata = ~wdata;
	endtask

	// Deselect through the second chip select with the processor strobe low
	task automatic deselect_three();
		cs_n = 2'h2;
		{cpu_n, ctrl_n, step_n, glob_n, gate_n} = 5'h0f;
	endtask

	initial begin
		addr = '0;
		wdata = '0;
		lane_n = 4'hf;
		idle();
	end
endmodule

// >>> dv/sync_burst_sram_port_tb.sv
module sync_burst_sram_port_tb import sync_burst_sram_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [ADDR_W-1:0] BASE = 22'h0048d0;
	logic core_clk = 0, srst = 1, oe_n = 0, sleep = 0, bypass = 1, lin_n = 1;
	logic [ADDR_W-1:0] addr;
	logic [1:0] cs_n;
	logic cpu_n, ctrl_n, step_n, glob_n, gate_n, data_oe;
	logic [3:0] lane_n;
	logic [DATA_W-1:0] wdata, data_out;
	int miscompares = 0, checks = 0, cycles = 0;

	host_bus_model host(.addr(addr), .cs_n(cs_n), .cpu_n(cpu_n), .ctrl_n(ctrl_n),
		.step_n(step_n), .glob_n(glob_n), .gate_n(gate_n), .lane_n(lane_n), .wdata(wdata));
	sync_burst_sram_port dut(.core_clk(core_clk), .srst(srst),
		.addr_upper(addr[ADDR_W-1:LSB_W]), .addr_lsb_zero(addr[0]), .addr_lsb_one(addr[1]),
		.chip_select_one_n(cs_n[0]), .chip_select_three_n(cs_n[1]),
		.addr_strobe_cpu_n(cpu_n), .addr_strobe_ctrl_n(ctrl_n), .burst_step_n(step_n),
		.byte_write_gate_n(gate_n), .all_bytes_write_n(glob_n), .byte_en_a_n(lane_n[0]),
		.byte_en_b_n(lane_n[1]), .byte_en_c_n(lane_n[2]), .byte_en_d_n(lane_n[3]),
		.output_enable_n(oe_n), .sleep_request(sleep), .bypass_select(bypass),
		.burst_order_linear_n(lin_n), .data_in(wdata), .data_out(data_out), .data_oe(data_oe));

	always #10 core_clk = ~core_clk;

	// Cut a hang short
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			finish_test();
		end
	end

	function automatic logic [DATA_W-1:0] pat(input int k);
		return 36'h5a5a5a5a0 + k;
	endfunction

	task automatic tick();
		@(negedge core_clk);
	endtask

	task automatic chk(input string n, input logic [DATA_W-1:0] s, e);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask

	task automatic op(input logic [4:0] c, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [3:0] ln = 4'hf);
		tick();
		host.drive(c, a, ln, d);
	endtask

	// Single read, then deselect; data and driver timing follow the mode
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		op(5'h0b, a, '0);
		tick();
		host.idle();
		if (bypass)
			tick();
		chk("rdata", data_out, e);
		chk("oe", data_oe, 1'b1);
		tick();
		chk("oe_off", data_oe, 1'b0);
	endtask

	task automatic finish_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (3) tick();
		srst = 0;
		chk("oe_rst", data_oe, 1'b0);
		// Linear write burst from low bits 01, read back word by word
		lin_n = 0;
		op(5'h15, BASE | 1, pat(0));
		for (int k = 1; k < 4; k++)
			op(5'h19, '0, pat(k));
		for (int k = 0; k < 4; k++)
			rd(BASE | ((k + 1) % 4), pat(k));
		// Interleaved flow-through read burst from 10, wraps on fifth beat
		lin_n = 1;
		bypass = 0;
		op(5'h0b, BASE | 2, '0);
		for (int k = 0; k < 5; k++) begin
			tick();
			host.drive(5'h1b, '0, 4'hf, '0);
			chk("burst", data_out, pat(((2 ^ (k % 4)) + 3) % 4));
		end
		// Flow-through single read, controller strobe read, suspend, second select off
		rd(BASE, pat(3));
		op(5'h17, BASE | 1, '0);
		op(5'h1f, '0, '0);
		chk("ctrl_read", data_out, pat(0));
		tick();
		host.deselect_three();
		chk("suspend", data_out, pat(0));
		tick();
		chk("cs3_off", data_oe, 1'b0);
		// Each lane alone, then no lane
		bypass = 1;
		for (int l = 0; l < 5; l++) begin
			op(5'h15, BASE, '1);
			op(5'h16, BASE, '0, ~(4'h1 << l));
			tick();
			chk("oe_wr", data_oe, 1'b0);
			host.idle();
			rd(BASE, ~(36'h1ff << (9 * l)));
		end
		// Write while asleep is lost, contents kept
		sleep = 1;
		op(5'h15, BASE, '0);
		tick();
		host.idle();
		sleep = 0;
		rd(BASE, '1);
		// Output enable and sleep gate the drivers at once
		op(5'h0b, BASE, '0);
		tick();
		host.idle();
		tick();
		oe_n = 1;
		#1 chk("oe_async", data_oe, 1'b0);
		oe_n = 0;
		#1 chk("oe_back", data_oe, 1'b1);
		sleep = 1;
		#1 chk("sleep_async", data_oe, 1'b0);
		sleep = 0;
		finish_test();
	end
endmodule
